// File: pkg/dual_timer_pkg.sv
package dual_timer_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] OFF_CNT0_VALUE = 8'h0D;
    localparam logic [7:0] OFF_CNT0_CTRL  = 8'h0E;
    localparam logic [7:0] OFF_CNT1_VALUE = 8'h10;
    localparam logic [7:0] OFF_CNT1_CTRL  = 8'h11;
    localparam logic [7:0] OFF_INTERRUPT_CONTROL_0      = 8'h0B;
    localparam logic [7:0] OFF_INTERRUPT_CONTROL_1      = 8'h1E;
    localparam logic [7:0] OFF_PORT_A     = 8'h12;

    ////////////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int         CTRL_EDGE_BIT  = 3;
    localparam int         CTRL_RUN_BIT   = 4;
    localparam int         CTRL_SRC_BIT   = 5;
    localparam int         CTRL_MODE_LSB  = 6;
    localparam int         CTRL_MODE_MSB  = 7;
    localparam logic [7:0] CTRL_USED_MASK = 8'hF8;
    localparam logic [7:0] CTRL_RESET     = 8'h08;
    localparam logic [1:0] MODE_EVENT     = 2'h1;
    localparam logic [1:0] MODE_TIMER     = 2'h2;
    localparam logic [1:0] MODE_PULSE     = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt control and port fields
    localparam int INTERRUPT_CONTROL_0_FLAG_BIT = 6;
    localparam int INTERRUPT_CONTROL_0_EN_BIT   = 2;
    localparam int INTERRUPT_CONTROL_1_FLAG_BIT = 4;
    localparam int INTERRUPT_CONTROL_1_EN_BIT   = 0;
    localparam int PORT_PFD_BIT   = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // Counting constants and build options
    localparam logic [7:0] COUNT_MAX      = 8'hFF;
    localparam logic [1:0] PRESCALE_LAST  = 2'h3;
    localparam int         OPT_SRC_CNT0   = 0;
    localparam int         OPT_SRC_SYSCLK = 1;
    localparam int         OPT_SRC_TBASE  = 2;

    typedef enum logic {
        PW_IDLE,
        PW_MEASURE
    } pw_state_t;

endpackage : dual_timer_pkg

// File: verilog/dual_timer_event_counter.sv
// The plain strobed port was left to the implementer.
module dual_timer_event_counter #(
    parameter int unsigned CNT0_SYSCLK_DIV4 = 0,
    parameter int unsigned CNT1_CLK_OPTION  = 0,
    parameter int unsigned PFD_COUNTER      = 0
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       rtc_timeout,
    input  wire logic       timebase_timeout,
    input  wire logic       counter0_value_and_event_pin,
    input  wire logic       counter1_value_and_event_pin,
    output logic            counter0_irq,
    output logic            counter1_irq,
    output logic            counter0_wakeup,
    output logic            counter1_wakeup,
    output logic            port_a_bit_three
);

    ////////////////////////////////////////////////////////////////////////////////
    // Build option checks
    generate
        if (CNT0_SYSCLK_DIV4 > 1 || CNT1_CLK_OPTION > dual_timer_pkg::OPT_SRC_TBASE || PFD_COUNTER > 1) begin : g_bad
            $error("Unsupported build option value");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [7:0]                  ctrl;
        logic [7:0]                  preload;
        logic [7:0]                  count;
        logic                        pin_meta;
        logic                        pin_sync;
        logic                        pin_prev;
        dual_timer_pkg::pw_state_t   pw;
    } cnt_state_t;

    typedef struct packed {
        cnt_state_t [1:0] cnt;
        logic [1:0]       flag;
        logic [1:0]       ien;
        logic             port_bit;
        logic [1:0]       pre_cnt;
        logic             pfd_toggle;
        logic             pin_out;
        logic [1:0]       wake;
        logic [1:0]       irq;
        logic [7:0]       rdata;
    } state_t;

    state_t     st_reg;
    state_t     st_next;
    logic [1:0] pins;
    logic [1:0] rd_val;
    logic [1:0] wr_val;
    logic [1:0] wr_ctrl;
    logic [1:0] wr_intc;
    logic [1:0] act_edge;
    logic [1:0] inact_edge;
    logic [1:0] int_tick;
    logic [1:0] tick;
    logic [1:0] ovf;
    logic       pre_tick;

    function automatic logic [7:0] value_off(input int i);
        value_off = (i == 0) ? dual_timer_pkg::OFF_CNT0_VALUE : dual_timer_pkg::OFF_CNT1_VALUE;
    endfunction : value_off

    function automatic logic [7:0] ctrl_off(input int i);
        ctrl_off = (i == 0) ? dual_timer_pkg::OFF_CNT0_CTRL : dual_timer_pkg::OFF_CNT1_CTRL;
    endfunction : ctrl_off

    function automatic logic [7:0] intc_off(input int i);
        intc_off = (i == 0) ? dual_timer_pkg::OFF_INTERRUPT_CONTROL_0 : dual_timer_pkg::OFF_INTERRUPT_CONTROL_1;
    endfunction : intc_off

    function automatic int flag_bit(input int i);
        flag_bit = (i == 0) ? dual_timer_pkg::INTERRUPT_CONTROL_0_FLAG_BIT : dual_timer_pkg::INTERRUPT_CONTROL_1_FLAG_BIT;
    endfunction : flag_bit

    function automatic int en_bit(input int i);
        en_bit = (i == 0) ? dual_timer_pkg::INTERRUPT_CONTROL_0_EN_BIT : dual_timer_pkg::INTERRUPT_CONTROL_1_EN_BIT;
    endfunction : en_bit

    function automatic logic [1:0] mode_of(input logic [7:0] c);
        mode_of = c[dual_timer_pkg::CTRL_MODE_MSB:dual_timer_pkg::CTRL_MODE_LSB];
    endfunction : mode_of

    assign pins = {counter1_value_and_event_pin, counter0_value_and_event_pin};

    ////////////////////////////////////////////////////////////////////////////////
    // Access decode
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            rd_val[i]  = rd && (addr == value_off(i));
            wr_val[i]  = wr && (addr == value_off(i));
            wr_ctrl[i] = wr && (addr == ctrl_off(i));
            wr_intc[i] = wr && (addr == intc_off(i));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_next    = st_reg;
        act_edge   = 2'h0;
        inact_edge = 2'h0;
        int_tick   = 2'h0;
        tick       = 2'h0;
        ovf        = 2'h0;
        // Free-running clock/4 prescaler shared by both counters
        pre_tick         = (st_reg.pre_cnt == dual_timer_pkg::PRESCALE_LAST);
        st_next.pre_cnt  = 2'(st_reg.pre_cnt + 2'h1);
        st_next.rdata    = 8'h00;

        for (int i = 0; i < 2; i++) begin
            // Pins cross in through two flops; edges seen only on the synced copy
            st_next.cnt[i].pin_meta = pins[i];
            st_next.cnt[i].pin_sync = st_reg.cnt[i].pin_meta;
            st_next.cnt[i].pin_prev = st_reg.cnt[i].pin_sync;
            if (st_reg.cnt[i].ctrl[dual_timer_pkg::CTRL_EDGE_BIT]) begin
                act_edge[i]   = st_reg.cnt[i].pin_prev && !st_reg.cnt[i].pin_sync;
                inact_edge[i] = !st_reg.cnt[i].pin_prev && st_reg.cnt[i].pin_sync;
            end else begin
                act_edge[i]   = !st_reg.cnt[i].pin_prev && st_reg.cnt[i].pin_sync;
                inact_edge[i] = st_reg.cnt[i].pin_prev && !st_reg.cnt[i].pin_sync;
            end

            // Internal clock selection
            if (i == 0) begin
                if (st_reg.cnt[i].ctrl[dual_timer_pkg::CTRL_SRC_BIT]) begin
                    int_tick[i] = (CNT0_SYSCLK_DIV4 != 0) ? pre_tick : 1'b1;
                end else begin
                    int_tick[i] = rtc_timeout;
                end
            end else begin
                if (st_reg.cnt[i].ctrl[dual_timer_pkg::CTRL_SRC_BIT]) begin
                    int_tick[i] = pre_tick;
                end else if (CNT1_CLK_OPTION == dual_timer_pkg::OPT_SRC_CNT0) begin
                    int_tick[i] = ovf[0];
                end else if (CNT1_CLK_OPTION == dual_timer_pkg::OPT_SRC_SYSCLK) begin
                    int_tick[i] = 1'b1;
                end else begin
                    int_tick[i] = timebase_timeout;
                end
            end

            // Mode and pulse measurement sequencing
            case (st_reg.cnt[i].pw)
                dual_timer_pkg::PW_IDLE: begin
                    if (st_reg.cnt[i].ctrl[dual_timer_pkg::CTRL_RUN_BIT] &&
                        mode_of(st_reg.cnt[i].ctrl) == dual_timer_pkg::MODE_PULSE && act_edge[i]) begin
                        st_next.cnt[i].pw = dual_timer_pkg::PW_MEASURE;
                    end
                end
                dual_timer_pkg::PW_MEASURE: begin
                    if (!st_reg.cnt[i].ctrl[dual_timer_pkg::CTRL_RUN_BIT] ||
                        mode_of(st_reg.cnt[i].ctrl) != dual_timer_pkg::MODE_PULSE) begin
                        st_next.cnt[i].pw = dual_timer_pkg::PW_IDLE;
                    end else if (inact_edge[i]) begin
                        // Run bit drops so later edges are ignored until software re-arms
                        st_next.cnt[i].pw = dual_timer_pkg::PW_IDLE;
                        st_next.cnt[i].ctrl[dual_timer_pkg::CTRL_RUN_BIT] = 1'b0;
                    end else begin
                        tick[i] = int_tick[i];
                    end
                end
                default: begin
                    st_next.cnt[i].pw = dual_timer_pkg::PW_IDLE;
                end
            endcase

            case (mode_of(st_reg.cnt[i].ctrl))
                dual_timer_pkg::MODE_EVENT: tick[i] = act_edge[i];
                dual_timer_pkg::MODE_TIMER: tick[i] = int_tick[i];
                dual_timer_pkg::MODE_PULSE: tick[i] = tick[i];
                default:                    tick[i] = 1'b0;
            endcase
            // A value read freezes the count so the byte read is coherent; that count is lost
            tick[i] = tick[i] && st_reg.cnt[i].ctrl[dual_timer_pkg::CTRL_RUN_BIT] && !rd_val[i];

            if (tick[i]) begin
                if (st_reg.cnt[i].count == dual_timer_pkg::COUNT_MAX) begin
                    ovf[i] = 1'b1;
                    st_next.cnt[i].count = wr_val[i] ? wdata : st_reg.cnt[i].preload;
                end else begin
                    st_next.cnt[i].count = 8'(st_reg.cnt[i].count + 8'h01);
                end
            end

            // Software writes
            if (wr_val[i]) begin
                st_next.cnt[i].preload = wdata;
                if (!st_reg.cnt[i].ctrl[dual_timer_pkg::CTRL_RUN_BIT]) begin
                    st_next.cnt[i].count = wdata;
                end
            end
            if (wr_ctrl[i]) begin
                // Software write wins over the automatic enable clear
                st_next.cnt[i].ctrl = wdata & dual_timer_pkg::CTRL_USED_MASK;
                st_next.cnt[i].pw   = dual_timer_pkg::PW_IDLE;
            end
            if (wr_intc[i]) begin
                st_next.flag[i] = wdata[flag_bit(i)];
                st_next.ien[i]  = wdata[en_bit(i)];
            end
            // Set wins over a clear written in the same cycle
            if (ovf[i]) begin
                st_next.flag[i] = 1'b1;
            end

            // Reads
            if (rd && addr == value_off(i)) begin
                st_next.rdata = st_reg.cnt[i].count;
            end
            if (rd && addr == ctrl_off(i)) begin
                st_next.rdata = st_reg.cnt[i].ctrl & dual_timer_pkg::CTRL_USED_MASK;
            end
            if (rd && addr == intc_off(i)) begin
                st_next.rdata[flag_bit(i)] = st_reg.flag[i];
                st_next.rdata[en_bit(i)]   = st_reg.ien[i];
            end
        end

        if (wr && addr == dual_timer_pkg::OFF_PORT_A) begin
            st_next.port_bit = wdata[dual_timer_pkg::PORT_PFD_BIT];
        end
        if (rd && addr == dual_timer_pkg::OFF_PORT_A) begin
            st_next.rdata[dual_timer_pkg::PORT_PFD_BIT] = st_reg.port_bit;
        end

        // Divider output toggles on each overflow of the chosen counter while the port bit is clear
        st_next.pfd_toggle = st_reg.pfd_toggle ^ ovf[PFD_COUNTER];
        st_next.pin_out    = st_next.port_bit ? 1'b1 : st_next.pfd_toggle;
        st_next.wake       = ovf;
        st_next.irq        = st_next.flag & st_next.ien;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
            for (int i = 0; i < 2; i++) begin
                st_reg.cnt[i].ctrl <= dual_timer_pkg::CTRL_RESET;
            end
            st_reg.port_bit <= 1'b1;
            st_reg.pin_out  <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata            = st_reg.rdata;
    assign counter0_irq     = st_reg.irq[0];
    assign counter1_irq     = st_reg.irq[1];
    assign counter0_wakeup  = st_reg.wake[0];
    assign counter1_wakeup  = st_reg.wake[1];
    assign port_a_bit_three = st_reg.pin_out;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    generate
        for (genvar g = 0; g < 2; g++) begin : g_chk
            ctrl_low_zero_a: assert property (rd && addr == ctrl_off(g) |=> rdata[2:0] == 3'h0)
                else $error("Control low bits not zero");
            value_read_a: assert property (rd_val[g] |=> rdata == $past(st_reg.cnt[g].count))
                else $error("Value read mismatch");
            overflow_reload_a: assert property (ovf[g] && !wr_val[g]
                |=> st_reg.cnt[g].count == $past(st_reg.cnt[g].preload) && st_reg.flag[g])
                else $error("Overflow reload or flag wrong");
            read_block_a: assert property (rd_val[g] |=> st_reg.cnt[g].count == $past(st_reg.cnt[g].count))
                else $error("Count moved during read");
            write_stopped_a: assert property (wr_val[g] && !st_reg.cnt[g].ctrl[dual_timer_pkg::CTRL_RUN_BIT]
                |=> st_reg.cnt[g].count == $past(wdata) && st_reg.cnt[g].preload == $past(wdata))
                else $error("Stopped write not loaded");
            write_running_a: assert property (wr_val[g] && st_reg.cnt[g].ctrl[dual_timer_pkg::CTRL_RUN_BIT] && !ovf[g]
                |=> st_reg.cnt[g].preload == $past(wdata) && st_reg.cnt[g].count != $past(wdata)
                    || st_reg.cnt[g].count == $past(st_reg.cnt[g].count)
                    || st_reg.cnt[g].count == 8'($past(st_reg.cnt[g].count) + 8'h01))
                else $error("Running write disturbed count");
            pulse_stop_a: assert property (st_reg.cnt[g].pw == dual_timer_pkg::PW_MEASURE && inact_edge[g]
                && !wr_ctrl[g] && st_reg.cnt[g].ctrl[dual_timer_pkg::CTRL_RUN_BIT]
                && mode_of(st_reg.cnt[g].ctrl) == dual_timer_pkg::MODE_PULSE
                |=> !st_reg.cnt[g].ctrl[dual_timer_pkg::CTRL_RUN_BIT] ##1
                    st_reg.cnt[g].pw == dual_timer_pkg::PW_IDLE)
                else $error("Pulse end did not clear enable");
            run_hold_a: assert property (mode_of(st_reg.cnt[g].ctrl) != dual_timer_pkg::MODE_PULSE
                && st_reg.cnt[g].ctrl[dual_timer_pkg::CTRL_RUN_BIT] && !wr_ctrl[g]
                |=> st_reg.cnt[g].ctrl[dual_timer_pkg::CTRL_RUN_BIT])
                else $error("Enable cleared outside pulse mode");
            irq_gate_a: assert property (ovf[g] && !wr_intc[g] |=> ##1 (st_reg.irq[g] == st_reg.ien[g]) || wr_intc[g]
                || $past(wr_intc[g]))
                else $error("Interrupt gating wrong");
            overflow_cov: cover property (ovf[g] ##1 st_reg.wake[g]);
            pulse_cov: cover property (st_reg.cnt[g].pw == dual_timer_pkg::PW_MEASURE ##[1:50]
                st_reg.cnt[g].pw == dual_timer_pkg::PW_IDLE);
        end
    endgenerate

    pfd_off_a: assert property (st_reg.port_bit |-> port_a_bit_three)
        else $error("Divider output not blocked");
    pfd_toggle_a: assert property (ovf[PFD_COUNTER] && !st_next.port_bit |=> $changed(port_a_bit_three))
        else $error("Divider output did not toggle");
    pfd_cov: cover property (!st_reg.port_bit ##1 $changed(port_a_bit_three));

endmodule : dual_timer_event_counter

// File: verif/event_source.sv
module event_source (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic lvl0,
    input  wire logic lvl1,
    output logic      rtc_timeout,
    output logic      timebase_timeout,
    output logic      pin0,
    output logic      pin1
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] div_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Free running divider: one-cycle timeout pulses, same clock as the counters
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end
    assign rtc_timeout      = (div_reg[2:0] == 3'h7);
    assign timebase_timeout = (div_reg[3:0] == 4'hF);

    // Pins are driven push-pull, so a level is always defined
    assign pin0 = lvl0;
    assign pin1 = lvl1;
endmodule : event_source

// File: verif/dual_timer_event_counter_tb.sv
module dual_timer_event_counter_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, rst, wr, rd, lvl0, lvl1, rtc, tbase, pin0, pin1;
    logic        irq0, irq1, wake0, wake1, frequency_divider_output;
    logic [7:0]  addr, wdata, rdata, d, c;
    logic [31:0] seed;
    int          error_cnt, samples_checked, n, h;

    event_source i_src (.clk(clk), .rst(rst), .lvl0(lvl0), .lvl1(lvl1), .rtc_timeout(rtc),
                        .timebase_timeout(tbase), .pin0(pin0), .pin1(pin1));
    dual_timer_event_counter i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .rtc_timeout(rtc), .timebase_timeout(tbase), .counter0_value_and_event_pin(pin0),
        .counter1_value_and_event_pin(pin1), .counter0_irq(irq0), .counter1_irq(irq1),
        .counter0_wakeup(wake0), .counter1_wakeup(wake1), .port_a_bit_three(frequency_divider_output));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic end_of_test();
        $display("errors %0d, comparisons %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg

    // Bounded wait for a wakeup pulse of counter 0
    task automatic wait_wake0(input int lim);
        int k;
        for (k = 0; k < lim && wake0 !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        if (k == lim) begin
            error_cnt++;
            end_of_test();
        end
    endtask : wait_wake0

    task automatic pulse_pin(input bit which, input int len);
        if (which) lvl1 <= 1'b1; else lvl0 <= 1'b1;
        repeat (len) @(posedge clk);
        if (which) lvl1 <= 1'b0; else lvl0 <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : pulse_pin

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end

    initial begin
        {rst, wr, rd, lvl0, lvl1} = 5'h10;
        addr = 8'h00; wdata = 8'h00; seed = 32'h4DB2;
        error_cnt = 0; samples_checked = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd_reg(8'h0E, d); check(d, 8'h08);
        rd_reg(8'h11, d); check(d, 8'h08);
        rd_reg(8'h20, d); check(d, 8'h00);
        check({7'h00, frequency_divider_output}, 8'h01);
        wr_reg(8'h11, 8'h2F); rd_reg(8'h11, d); check(d, 8'h28);
        // Stopped counters take a written value at once, both counters
        for (int i = 0; i < 6; i++) begin
            seed = lfsr_next(seed);
            wr_reg(i[0] ? 8'h10 : 8'h0D, seed[7:0]);
            rd_reg(i[0] ? 8'h10 : 8'h0D, d); check(d, seed[7:0]);
        end
        // Timer overflow with interrupt enabled
        wr_reg(8'h0D, 8'hFD); wr_reg(8'h0B, 8'h04); wr_reg(8'h0E, 8'hB0);
        wait_wake0(20);
        check({7'h00, irq0}, 8'h01);
        wr_reg(8'h0D, 8'h33); wr_reg(8'h0E, 8'h80);
        rd_reg(8'h0D, d); check({7'h00, d == 8'h33}, 8'h00);
        rd_reg(8'h0B, d); check(d & 8'h44, 8'h44);
        rd_reg(8'h0E, d); check(d, 8'h80);
        wr_reg(8'h0B, 8'h00); rd_reg(8'h0B, d); check(d & 8'h44, 8'h00);
        // Masked interrupt: flag rises, request stays low
        wr_reg(8'h0D, 8'hFE); wr_reg(8'h0E, 8'hB0); wait_wake0(20);
        repeat (2) @(posedge clk);
        check({7'h00, irq0}, 8'h00);
        rd_reg(8'h0B, d); check(d & 8'h40, 8'h40);
        // Divider output follows overflows while port bit is clear
        wr_reg(8'h0D, 8'hF0); wr_reg(8'h12, 8'h00);
        d = {7'h00, frequency_divider_output};
        for (n = 0; n < 60 && frequency_divider_output === d[0]; n++) @(posedge clk);
        check({7'h00, n < 60}, 8'h01);
        wr_reg(8'h12, 8'h08); repeat (40) @(posedge clk);
        check({7'h00, frequency_divider_output}, 8'h01);
        wr_reg(8'h0E, 8'h80); wr_reg(8'h0B, 8'h00);
        // Event count on both edge polarities; one extra rising edge at the end
        for (int e = 0; e < 2; e++) begin
            seed = lfsr_next(seed);
            n = seed[3:0] + 1;
            wr_reg(8'h11, 8'h40); wr_reg(8'h10, 8'h00);
            wr_reg(8'h11, e ? 8'h58 : 8'h50); repeat (4) @(posedge clk);
            repeat (n) pulse_pin(1'b1, 4);
            lvl1 <= 1'b1; repeat (6) @(posedge clk);
            rd_reg(8'h10, d); check(d, e ? n[7:0] : n[7:0] + 8'h01);
            wr_reg(8'h11, 8'h40); lvl1 <= 1'b0;
        end
        // Pulse width: one measurement, then later pulses ignored
        seed = lfsr_next(seed);
        h = seed[4:0] + 8;
        wr_reg(8'h0D, 8'h00); wr_reg(8'h0E, 8'hF0); repeat (4) @(posedge clk);
        pulse_pin(1'b0, h);
        rd_reg(8'h0E, d); check(d, 8'hE0);
        rd_reg(8'h0D, c); check({7'h00, c >= h - 1 && c <= h + 1}, 8'h01);
        pulse_pin(1'b0, 10);
        rd_reg(8'h0D, d); check(d, c);
        // Clock sources: counter 0 on timeout pulses, counter 1 on clock/4
        wr_reg(8'h0E, 8'h80); wr_reg(8'h0D, 8'h00); wr_reg(8'h11, 8'h80); wr_reg(8'h10, 8'h00);
        wr_reg(8'h0E, 8'h90); wr_reg(8'h11, 8'hB0);
        repeat (78) @(posedge clk);
        wr_reg(8'h0E, 8'h80); wr_reg(8'h11, 8'h80);
        rd_reg(8'h0D, d); check({7'h00, d >= 8'h09 && d <= 8'h0B}, 8'h01);
        rd_reg(8'h10, d); check({7'h00, d >= 8'h13 && d <= 8'h15}, 8'h01);
        end_of_test();
    end
endmodule : dual_timer_event_counter_tb
